// File: hw/remote_output_and_energy_pulse.sv
// remote output word, retention handling and energy pulse output
`include "remote_output_defines.svh"

module remote_output_and_energy_pulse #(
  parameter int NUM_TERMINALS = 2,
  parameter int PULSE_CYCLES = `ROE_PULSE_CYCLES,
  parameter int WH_PER_KWH = `ROE_WH_PER_KWH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire remote_output_pkg::param_wr_t param_wr,
  input wire logic [7:0] extended_parameter_visibility,
  input wire logic [3:0] parameter_write_protect,
  input wire logic drive_reset,
  input wire logic power_off_event,
  input wire logic nvm_restore,
  input wire logic [3:0] nvm_restore_mode,
  input wire logic [11:0] nvm_restore_word,
  input wire logic energy_tick,
  input wire logic [NUM_TERMINALS-1:0][7:0] terminal_function_select,
  input wire logic [NUM_TERMINALS-1:0] assigned_function_level,
  output logic [NUM_TERMINALS-1:0] terminal_out,
  output logic energy_pulse_output,
  output logic nvm_save_strobe,
  output logic [11:0] nvm_save_word,
  output logic [3:0] remote_output_retention_mode,
  output logic [11:0] remote_output_word,
  output logic [15:0] energy_pulse_increment
);
  import remote_output_pkg::*;

  initial begin
    if (NUM_TERMINALS < 1 || NUM_TERMINALS > 12) $error("NUM_TERMINALS must be 1 to 12");
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) $error("PULSE_CYCLES must be 1 to 65535");
    if (WH_PER_KWH < 1 || WH_PER_KWH > 65535) $error("WH_PER_KWH must be 1 to 65535");
  end

  localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYCLES);
  localparam logic [15:0] WH_LAST = 16'(WH_PER_KWH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // parameter writes

  wire vis_ok = (extended_parameter_visibility == 8'h00);
  wire prot_ok = (parameter_write_protect == 4'h0);
  wire [3:0] wr_mode_val = param_wr.data[3:0];
  wire mode_legal = (param_wr.data[15:4] == 12'h000) &&
                    (wr_mode_val == `ROE_MODE_CLR || wr_mode_val == `ROE_MODE_NVM ||
                     wr_mode_val == `ROE_MODE_HOLD_CLR || wr_mode_val == `ROE_MODE_HOLD_NVM);
  wire wr_mode = param_wr.en && vis_ok && prot_ok && param_wr.sel == `ROE_SEL_MODE &&
                 mode_legal;
  // the word ignores write protection and run state: it is a live output
  wire wr_word = param_wr.en && vis_ok && param_wr.sel == `ROE_SEL_WORD &&
                 param_wr.data[15:12] == 4'h0;
  wire wr_inc = param_wr.en && vis_ok && prot_ok && param_wr.sel == `ROE_SEL_INC;

  wire mode_nvm = remote_output_retention_mode == `ROE_MODE_NVM ||
                  remote_output_retention_mode == `ROE_MODE_HOLD_NVM;
  wire mode_hold = remote_output_retention_mode == `ROE_MODE_HOLD_CLR ||
                   remote_output_retention_mode == `ROE_MODE_HOLD_NVM;
  wire restore_nvm = nvm_restore_mode == `ROE_MODE_NVM ||
                     nvm_restore_mode == `ROE_MODE_HOLD_NVM;

  // image of the nonvolatile copy, so mode 1 can reapply it after a drive reset
  logic [11:0] saved_word;

  ////////////////////////////////////////////////////////////////////////////
  // retention and remote output word

  logic [11:0] next_word;
  always_comb begin
    next_word = remote_output_word;
    if (nvm_restore) begin
      next_word = restore_nvm ? nvm_restore_word : `ROE_WORD_RST;
    end else if (drive_reset) begin
      if (mode_hold) begin
        next_word = remote_output_word;
      end else if (mode_nvm) begin
        next_word = saved_word;
      end else begin
        next_word = `ROE_WORD_RST;
      end
    end else if (wr_word) begin
      next_word = param_wr.data[11:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      remote_output_word <= `ROE_WORD_RST;
      remote_output_retention_mode <= `ROE_MODE_RST;
      energy_pulse_increment <= `ROE_INC_RST;
      saved_word <= `ROE_WORD_RST;
      nvm_save_strobe <= 1'b0;
      nvm_save_word <= `ROE_WORD_RST;
    end else begin
      remote_output_word <= next_word;
      if (nvm_restore) begin
        remote_output_retention_mode <= nvm_restore_mode;
        saved_word <= nvm_restore_word;
      end else if (wr_mode) begin
        remote_output_retention_mode <= wr_mode_val;
      end else if (power_off_event && mode_nvm) begin
        saved_word <= remote_output_word;
      end
      if (wr_inc) begin
        energy_pulse_increment <= param_wr.data;
      end
      // only power off saves; a drive reset never does
      nvm_save_strobe <= power_off_event && mode_nvm;
      if (power_off_event && mode_nvm) begin
        nvm_save_word <= remote_output_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy accumulation

  logic [15:0] wh_count;
  logic [15:0] kwh_count;
  logic [3:0] pending;
  pulse_state_t state;
  logic [15:0] pulse_count;

  wire wh_wrap = energy_tick && wh_count == WH_LAST;
  wire [15:0] kwh_plus = kwh_count + 16'h0001;
  wire inc_live = energy_pulse_increment != 16'h0000;
  wire pulse_due = wh_wrap && inc_live && kwh_plus >= energy_pulse_increment;
  wire pulse_start = state == ST_IDLE && pending != 4'h0;
  wire pend_up = pulse_due && pending != 4'hF;

  // drive reset and power-on alone clear the count; retries do not reach here
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wh_count <= 16'h0000;
      kwh_count <= 16'h0000;
      pending <= 4'h0;
    end else if (drive_reset) begin
      wh_count <= 16'h0000;
      kwh_count <= 16'h0000;
      pending <= 4'h0;
    end else begin
      if (energy_tick) begin
        wh_count <= wh_wrap ? 16'h0000 : wh_count + 16'h0001;
      end
      if (wh_wrap) begin
        kwh_count <= pulse_due ? 16'h0000 : kwh_plus;
      end
      // pulses are queued so a burst of increments is not lost, at most 15 deep
      pending <= pending + (pend_up ? 4'h1 : 4'h0) - (pulse_start ? 4'h1 : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse shaper: high for PULSE_CYCLES, then low for at least PULSE_CYCLES + 1

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      pulse_count <= 16'h0000;
      energy_pulse_output <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pulse_start) begin
            state <= ST_HIGH;
            pulse_count <= 16'h0001;
            energy_pulse_output <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (pulse_count == PULSE_LEN) begin
            state <= ST_GAP;
            pulse_count <= 16'h0001;
            energy_pulse_output <= 1'b0;
          end else begin
            pulse_count <= pulse_count + 16'h0001;
          end
        end
        ST_GAP: begin
          if (pulse_count == PULSE_LEN) begin
            state <= ST_IDLE;
            pulse_count <= 16'h0000;
          end else begin
            pulse_count <= pulse_count + 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
          pulse_count <= 16'h0000;
          energy_pulse_output <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal selection, terminal k carries word bit k when set to a remote output code

  logic [NUM_TERMINALS-1:0] next_terminal;
  genvar k;
  generate
    for (k = 0; k < NUM_TERMINALS; k++) begin : g_term
      wire [7:0] fs = terminal_function_select[k];
      wire is_rem = fs == `ROE_FN_REM_POS || fs == `ROE_FN_REM_NEG;
      wire is_pulse = fs == `ROE_FN_PULSE_POS || fs == `ROE_FN_PULSE_NEG;
      wire rem_level = remote_output_word[k] ^ (fs == `ROE_FN_REM_NEG);
      wire pulse_level = energy_pulse_output ^ (fs == `ROE_FN_PULSE_NEG);
      assign next_terminal[k] = is_rem ? rem_level :
                                is_pulse ? pulse_level : assigned_function_level[k];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      terminal_out <= '0;
    end else begin
      terminal_out <= next_terminal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] hi_len;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_len <= 16'h0000;
    end else begin
      hi_len <= energy_pulse_output ? hi_len + 16'h0001 : 16'h0000;
    end
  end

  sequence s_drive_reset_kept;
    drive_reset && !nvm_restore && mode_hold;
  endsequence
  sequence s_drive_reset_mode1;
    drive_reset && !nvm_restore && remote_output_retention_mode == `ROE_MODE_NVM;
  endsequence

  chk_pulse_width: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(energy_pulse_output) |-> hi_len == PULSE_LEN)
    else $error("energy pulse width wrong");
  chk_pulse_spacing: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(energy_pulse_output) |=> !energy_pulse_output [*2])
    else $error("energy pulses merged");
  chk_due_pulses: assert property (@(posedge mclk) disable iff (!rst_b)
    pulse_due && !drive_reset && pending == 4'h0 && state == ST_IDLE |-> ##2 energy_pulse_output)
    else $error("energy pulse not started");
  chk_hold_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    s_drive_reset_kept |=> $stable(remote_output_word))
    else $error("word lost over drive reset");
  chk_mode1_restore: assert property (@(posedge mclk) disable iff (!rst_b)
    s_drive_reset_mode1 |=> remote_output_word == $past(saved_word))
    else $error("mode 1 did not apply saved word");
  chk_clear_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    drive_reset && !nvm_restore && remote_output_retention_mode == `ROE_MODE_CLR
    |=> remote_output_word == `ROE_WORD_RST)
    else $error("mode 0 kept word over drive reset");
  chk_save_power: assert property (@(posedge mclk) disable iff (!rst_b)
    nvm_save_strobe |-> $past(power_off_event) && nvm_save_word == $past(remote_output_word))
    else $error("unexpected save strobe");
  chk_word_write: assert property (@(posedge mclk) disable iff (!rst_b)
    param_wr.en && param_wr.sel == `ROE_SEL_WORD && vis_ok && param_wr.data[15:12] == 4'h0
    && !drive_reset && !nvm_restore |=> remote_output_word == $past(param_wr.data[11:0]))
    else $error("word write not taken");
  chk_vis_block: assert property (@(posedge mclk) disable iff (!rst_b)
    param_wr.en && !vis_ok && !drive_reset && !nvm_restore
    |=> $stable(remote_output_word) && $stable(energy_pulse_increment))
    else $error("write taken with extended visibility set");
  chk_rem_terminal: assert property (@(posedge mclk) disable iff (!rst_b)
    terminal_function_select[0] == `ROE_FN_REM_NEG
    |=> terminal_out[0] == !$past(remote_output_word[0]))
    else $error("negative logic terminal wrong");

endmodule : remote_output_and_energy_pulse

// File: shared/remote_output_defines.svh
// constants for the remote output and energy pulse block
`ifndef REMOTE_OUTPUT_DEFINES_SVH
`define REMOTE_OUTPUT_DEFINES_SVH

// parameter select codes on the parameter write port
`define ROE_SEL_MODE 2'h0
`define ROE_SEL_WORD 2'h1
`define ROE_SEL_INC 2'h2

// reset values
`define ROE_MODE_RST 4'h0
`define ROE_WORD_RST 12'h000
`define ROE_INC_RST 16'h0001

// retention mode settings (decimal 0, 1, 10, 11)
`define ROE_MODE_CLR 4'h0
`define ROE_MODE_NVM 4'h1
`define ROE_MODE_HOLD_CLR 4'hA
`define ROE_MODE_HOLD_NVM 4'hB

// terminal function codes (96, 196, 79, 179)
`define ROE_FN_REM_POS 8'h60
`define ROE_FN_REM_NEG 8'hC4
`define ROE_FN_PULSE_POS 8'h4F
`define ROE_FN_PULSE_NEG 8'hB3

// timing
`define ROE_CLK_HZ 50000000
`define ROE_PULSE_TIME_US 100
`define ROE_PULSE_CYCLES ((`ROE_CLK_HZ / 1000000) * `ROE_PULSE_TIME_US)
`define ROE_WH_PER_KWH 1000

`endif

// File: shared/remote_output_pkg.sv
// types for the remote output and energy pulse block
package remote_output_pkg;

  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic [15:0] data;
  } param_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_GAP = 2'b11
  } pulse_state_t;

endpackage : remote_output_pkg

// File: tb/host_link_model.sv
// host side model: parameter writes and terminal function selection
module host_link_model (
  input wire logic mclk,
  output remote_output_pkg::param_wr_t param_wr,
  output logic [1:0][7:0] terminal_function_select
);
  timeunit 1ns;
  timeprecision 1ps;
  import remote_output_pkg::*;

  initial begin
    param_wr = '0;
    terminal_function_select = '0;
  end

  // data turns to its inverse once released, so a stale bus is never read as valid
  task automatic write_param(input logic [1:0] sel, input logic [15:0] data);
    @(posedge mclk);
    param_wr <= '{en: 1'b1, sel: sel, data: data};
    @(posedge mclk);
    param_wr <= '{en: 1'b0, sel: ~sel, data: ~data};
  endtask : write_param

  task automatic set_function(input int k, input logic [7:0] code);
    @(posedge mclk);
    terminal_function_select[k] <= code;
    repeat (2) @(posedge mclk);
    #1;
  endtask : set_function
endmodule : host_link_model

// File: tb/remote_output_and_energy_pulse_tb.sv
// self-checking bench for the remote output and energy pulse block
`include "remote_output_defines.svh"
module remote_output_and_energy_pulse_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import remote_output_pkg::*;
  localparam int PC = 2;
  localparam int WH = 2;
  logic mclk;
  logic rst_b;
  logic [7:0] vis;
  logic [3:0] prot;
  logic [3:0] ev;
  logic [3:0] rmode;
  logic [11:0] rword;
  logic [1:0] afl;
  param_wr_t param_wr;
  logic [1:0][7:0] fsel;
  logic [1:0] term;
  logic pulse;
  logic stb;
  logic [11:0] sword;
  logic [3:0] mode;
  logic [11:0] word;
  logic [15:0] inc;
  int err_count;
  int checks_done;

  host_link_model host_u (.mclk(mclk), .param_wr(param_wr), .terminal_function_select(fsel));

  remote_output_and_energy_pulse #(.PULSE_CYCLES(PC), .WH_PER_KWH(WH)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .param_wr(param_wr),
    .extended_parameter_visibility(vis), .parameter_write_protect(prot),
    .drive_reset(ev[0]), .power_off_event(ev[1]), .nvm_restore(ev[2]),
    .nvm_restore_mode(rmode), .nvm_restore_word(rword), .energy_tick(ev[3]),
    .terminal_function_select(fsel), .assigned_function_level(afl),
    .terminal_out(term), .energy_pulse_output(pulse), .nvm_save_strobe(stb),
    .nvm_save_word(sword), .remote_output_retention_mode(mode),
    .remote_output_word(word), .energy_pulse_increment(inc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    host_u.write_param(sel, d);
    @(posedge mclk);
    #1;
  endtask : wr

  // bit 0 drive reset, 1 power off, 2 nvm restore
  task automatic fire(input int i);
    @(posedge mclk);
    ev <= 4'h1 << i;
    @(posedge mclk);
    ev <= 4'h0;
    #1;
  endtask : fire

  task automatic rst_pulse();
    @(posedge mclk);
    rst_b <= 1'b0;
    @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
  endtask : rst_pulse

  // ticks go back to back while rises and high cycles are counted
  task automatic energy(input int n, input int rises);
    int seen;
    int high;
    int tpulse;
    logic last;
    seen = 0;
    high = 0;
    tpulse = 0;
    last = 1'b0;
    for (int c = 0; c < n + 8 * PC; c++) begin
      @(posedge mclk);
      ev <= (c < n) ? 4'h8 : 4'h0;
      #1;
      if (pulse === 1'b1 && !last) seen++;
      if (pulse === 1'b1) high++;
      // terminal 0 carries the inverted pulse, terminal 1 the plain one
      if (term === 2'b10) tpulse++;
      last = (pulse === 1'b1);
    end
    chk("pulse count", 16'(rises), 16'(seen));
    chk("pulse cycles", 16'(rises * PC), 16'(high));
    chk("terminal pulse", 16'(rises * PC), 16'(tpulse));
  endtask : energy

  ////////////////////////////////////////////////////////////////////////////
  task automatic terminals();
    host_u.set_function(0, `ROE_FN_REM_POS);
    host_u.set_function(1, `ROE_FN_REM_NEG);
    wr(`ROE_SEL_WORD, 16'h0001);
    chk("term a", 16'h0003, {14'h0, term});
    wr(`ROE_SEL_WORD, 16'h0FFE);
    chk("term b", 16'h0000, {14'h0, term});
    chk("word max", 16'h0FFE, {4'h0, word});
    afl <= 2'b10;
    host_u.set_function(1, 8'h0C);
    chk("term other", 16'h0002, {14'h0, term});
    host_u.set_function(0, `ROE_FN_PULSE_NEG);
    chk("term idle pulse", 16'h0003, {14'h0, term});
    host_u.set_function(0, `ROE_FN_REM_NEG);
    chk("term neg", 16'h0003, {14'h0, term});
  endtask : terminals

  task automatic protection();
    @(posedge mclk);
    prot <= 4'h1;
    wr(`ROE_SEL_WORD, 16'h00C3);
    chk("word protect", 16'h00C3, {4'h0, word});
    wr(`ROE_SEL_MODE, 16'h0001);
    chk("mode protect", 16'h0000, {12'h0, mode});
    prot <= 4'h0;
    vis <= 8'h01;
    wr(`ROE_SEL_WORD, 16'h0011);
    chk("word hidden", 16'h00C3, {4'h0, word});
    wr(`ROE_SEL_INC, 16'h0005);
    chk("inc hidden", 16'h0001, inc);
    vis <= 8'h00;
    wr(`ROE_SEL_MODE, 16'h0002);
    chk("mode illegal", 16'h0000, {12'h0, mode});
    wr(`ROE_SEL_WORD, 16'h1000);
    chk("word range", 16'h00C3, {4'h0, word});
  endtask : protection

  task automatic retention();
    wr(`ROE_SEL_MODE, 16'h0001);
    wr(`ROE_SEL_WORD, 16'h0005);
    fire(1);
    chk("save strobe", 16'h0001, {15'h0, stb});
    chk("save word", 16'h0005, {4'h0, sword});
    wr(`ROE_SEL_WORD, 16'h000A);
    fire(0);
    chk("word mode1 reset", 16'h0005, {4'h0, word});
    wr(`ROE_SEL_MODE, 16'h000B);
    wr(`ROE_SEL_WORD, 16'h0003);
    fire(0);
    chk("word hold", 16'h0003, {4'h0, word});
    wr(`ROE_SEL_MODE, 16'h0000);
    fire(1);
    chk("no save", 16'h0000, {15'h0, stb});
    fire(0);
    chk("word clear", 16'h0000, {4'h0, word});
    rmode <= 4'h1;
    rword <= 12'h009;
    fire(2);
    chk("restore word", 16'h0009, {4'h0, word});
    rmode <= 4'hA;
    fire(2);
    chk("restore clear", 16'h0000, {4'h0, word});
    wr(`ROE_SEL_WORD, 16'h0007);
    rst_pulse();
    chk("power on word", 16'h0000, {4'h0, word});
  endtask : retention

  task automatic pulses();
    host_u.set_function(0, `ROE_FN_PULSE_NEG);
    host_u.set_function(1, `ROE_FN_PULSE_POS);
    energy(4, 2);
    wr(`ROE_SEL_INC, 16'h0002);
    energy(4, 1);
    energy(2, 0);
    fire(0);
    energy(2, 0);
    rst_pulse();
    energy(1, 0);
    rst_pulse();
    energy(1, 0);
    energy(2, 1);
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    vis = 8'h00;
    prot = 4'h0;
    ev = 4'h0;
    rmode = 4'h0;
    rword = 12'h000;
    afl = 2'b00;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("reset inc", 16'h0001, inc);
    chk("reset word", 16'h0000, {4'h0, word});
    terminals();
    protection();
    retention();
    pulses();
    complete_run();
  end
endmodule : remote_output_and_energy_pulse_tb
